/* sim/handler_model.sv */
// Handler model: asks for a test, lets start go once busy shows.
// Bench decides when to ask and whether the interlock is in place.
`timescale 1ns/1ns
module handler_model (
  // Clock, bench controls and port pins
  input  wire logic CLK_SYS_I,
  input  wire logic go_i,
  input  wire logic lock_i,
  input  wire logic measure_active_n_i,
  output logic      start_n_o,
  output logic      interlock_n_o
);
  logic seen;
  // Remember busy so one request gives one test
  always_ff @(posedge CLK_SYS_I) begin
    if (!go_i) seen <= 1'b0;
    else if (!measure_active_n_i) seen <= 1'b1;
  end
  // Released line is driven high by the model itself
  // Next part only after busy has gone back high
  assign start_n_o = !(go_i && !seen && measure_active_n_i);
  assign interlock_n_o = !lock_i;
endmodule : handler_model

/* sim/handler_port_chk.sv */
// Pin-level checker for the handler sorting port.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ns
module handler_port_chk
  import handler_port_pkg::*;
#(parameter int SETUP_CYCLES = SETUP_CYC) (
  // Clock, reset, handler pins, interrupt and start pulse
  input wire logic               CLK_SYS_I,
  input wire logic               RST_I,
  input wire logic               START_COMB_N_I,
  input wire logic               INTERLOCK_N_I,
  input wire logic [CLASS_W-1:0] SORT_CLASS_N_O,
  input wire logic               MEASURE_ACTIVE_N_O,
  input wire logic               END_OF_TEST_N_O,
  input wire logic               IRQ_O,
  input wire logic               TEST_START_O
);
  logic [15:0] hold;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Cycles since the classes last moved, saturating; the change is seen
  // one edge late, so that edge already counts as one cycle of setup
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) hold <= '0;
    else if ($changed(SORT_CLASS_N_O)) hold <= 16'h1;
    else if (hold != 16'hffff) hold <= hold + 16'h1;
  end
  property p_start;
    $rose(TEST_START_O) |-> !$past(START_COMB_N_I) && !$past(INTERLOCK_N_I);
  endproperty
  a_start: assert property (p_start) else $error("start unasked");
  property p_answer;
    TEST_START_O |=> !MEASURE_ACTIVE_N_O && END_OF_TEST_N_O;
  endproperty
  a_answer: assert property (p_answer) else $error("no busy");
  property p_ignore; TEST_START_O |-> MEASURE_ACTIVE_N_O; endproperty
  a_ignore: assert property (p_ignore) else $error("start in test");
  property p_end; $rose(MEASURE_ACTIVE_N_O) |-> $fell(END_OF_TEST_N_O); endproperty
  a_end: assert property (p_end) else $error("busy alone");
  property p_eot; $fell(END_OF_TEST_N_O) |-> $rose(MEASURE_ACTIVE_N_O); endproperty
  a_eot: assert property (p_eot) else $error("eot alone");
  property p_setup;
    $rose(MEASURE_ACTIVE_N_O) |-> hold >= SETUP_CYCLES;
  endproperty
  a_setup: assert property (p_setup) else $error("setup short");
  property p_cls;
    $changed(SORT_CLASS_N_O) |-> !MEASURE_ACTIVE_N_O && END_OF_TEST_N_O;
  endproperty
  a_cls: assert property (p_cls) else $error("classes moved");
  property p_held; !MEASURE_ACTIVE_N_O |-> END_OF_TEST_N_O; endproperty
  a_held: assert property (p_held) else $error("eot in test");
  c_start: cover property (TEST_START_O);
  c_end: cover property ($fell(END_OF_TEST_N_O));
  c_irq: cover property ($rose(IRQ_O));
endmodule : handler_port_chk
bind component_handler_sort_port handler_port_chk
  #(.SETUP_CYCLES(SETUP_CYCLES)) i_chk (.CLK_SYS_I(CLK_SYS_I),
  .RST_I(RST_I), .START_COMB_N_I(START_COMB_N_I),
  .INTERLOCK_N_I(INTERLOCK_N_I), .SORT_CLASS_N_O(SORT_CLASS_N_O),
  .MEASURE_ACTIVE_N_O(MEASURE_ACTIVE_N_O), .IRQ_O(IRQ_O),
  .END_OF_TEST_N_O(END_OF_TEST_N_O), .TEST_START_O(TEST_START_O));

/* sim/tb_component_handler_sort_port.sv */
// Bench for the handler sorting port: AHB tasks, handler model, checks.
// Assumes a zero-wait slave and a short setup count.
`timescale 1ns/1ns
module tb_component_handler_sort_port
  import handler_port_pkg::*;
;
  localparam int SETUP = 4;
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, go = 1'b0, lock = 1'b0;
  logic hrdy, hresp, busy_n, eot_n, irq, tstart, start_n, ilock_n;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_val;
  logic [CLASS_W-1:0] cls_n;
  logic [31:0] exp_q[$];
  int fails = 0, checks_done = 0;
  event rd_ev;
  always #5 clk = ~clk;
  component_handler_sort_port #(.SETUP_CYCLES(SETUP)) i_dut (
    .CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .START_COMB_N_I(start_n),
    .INTERLOCK_N_I(ilock_n), .SORT_CLASS_N_O(cls_n), .IRQ_O(irq),
    .MEASURE_ACTIVE_N_O(busy_n), .END_OF_TEST_N_O(eot_n),
    .TEST_START_O(tstart));
  handler_model i_hdl (.CLK_SYS_I(clk), .go_i(go), .lock_i(lock),
    .measure_active_n_i(busy_n), .start_n_o(start_n),
    .interlock_n_o(ilock_n));
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo();
    fails++;
    stop_test();
  endtask : tmo
  // Edge at which hready is seen high; bounded
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) tmo();
  endtask : rdy
  // One single word transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    chk("hresp", 32'h0, hresp);
    if (!w) begin
      rd_val = hrdata;
      -> rd_ev;
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Wait at falling edges for the start pulse (0) or end of test (1)
  task automatic till(input int k);
    int n;
    for (n = 0; n < 200 && (k == 0 ? tstart : !eot_n) !== 1'b1; n++)
      @(negedge clk);
    if ((k == 0 ? tstart : !eot_n) !== 1'b1) tmo();
  endtask : till
  // Reads are judged here against the oldest note
  always @(rd_ev) chk("hrdata", exp_q.pop_front(), rd_val);
  initial begin
    logic [15:0] pat, prev;
    int k;
    k = $urandom(32'hc7a6);
    prev = 16'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pins", 32'h3ffff, {cls_n, busy_n, eot_n});
    rd(8'h20, 32'h0);
    @(posedge clk);
    go <= 1'b1;
    repeat (4) @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    chk("tstart", 32'h0, tstart);
    chk("irq masked", 32'h0, irq);
    rd(IRQ_ST_OFS, 32'h4);
    bus(1'b1, IRQ_EN_OFS, 32'h7);
    repeat (2) @(negedge clk);
    chk("irq", 32'h1, irq);
    bus(1'b1, IRQ_CLR_OFS, 32'h7);
    rd(IRQ_ST_OFS, 32'h0);
    lock <= 1'b1;
    // Every class once, then one random pattern
    for (k = 0; k <= 16; k++) begin
      pat = (k < 16) ? 16'h1 << k : 16'($urandom);
      @(posedge clk);
      go <= 1'b1;
      till(0);
      @(negedge clk);
      chk("busy eot", 32'h1, {busy_n, eot_n});
      chk("held", {16'h0, ~prev}, cls_n);
      @(posedge clk);
      go <= 1'b0;
      rd(STATUS_OFS, 32'h1);
      bus(1'b1, RESULT_OFS, {16'h0, pat});
      bus(1'b1, CTRL_OFS, 32'h1);
      till(1);
      chk("classes", {16'h0, ~pat}, cls_n);
      chk("busy", 32'h1, busy_n);
      rd(OUTPORT_OFS, {14'h0, 2'b10, pat});
      rd(IRQ_ST_OFS, 32'h7);
      bus(1'b1, IRQ_CLR_OFS, 32'h7);
      prev = pat;
    end
    stop_test();
  end
endmodule : tb_component_handler_sort_port

/* verilog/component_handler_sort_port.sv */
// Handler sorting and handshake port with an AHB-Lite register slave.
// Assumes handler inputs are already synchronous to CLK_SYS_I; the module
// itself inverts each output port bit onto the pins.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module component_handler_sort_port
  import handler_port_pkg::*;
#(
  parameter int SETUP_CYCLES = SETUP_CYC
) (
  // Clock and reset
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 RST_I,
  // AHB-Lite slave
  input  wire logic                 HSEL_I,
  input  wire logic [31:0]          HADDR_I,
  input  wire logic [1:0]           HTRANS_I,
  input  wire logic                 HWRITE_I,
  input  wire logic [2:0]           HSIZE_I,
  input  wire logic [31:0]          HWDATA_I,
  input  wire logic                 HREADY_I,
  output logic      [31:0]          HRDATA_O,
  output logic                      HREADYOUT_O,
  output logic                      HRESP_O,
  // Handler inputs, low when active
  input  wire logic                 START_COMB_N_I,
  input  wire logic                 INTERLOCK_N_I,
  // Handler outputs, low when asserted
  output logic      [CLASS_W-1:0]   SORT_CLASS_N_O,
  output logic                      MEASURE_ACTIVE_N_O,
  output logic                      END_OF_TEST_N_O,
  // Interrupt and start pulse to the measurement engine
  output logic                      IRQ_O,
  output logic                      TEST_START_O
);

  // Elaboration check: setup counter needs at least one cycle
  if (SETUP_CYCLES < 1 || SETUP_CYCLES > 65535) begin : g_bad_setup
    $error("SETUP_CYCLES out of range");
  end

  handler_in_t            pins;
  test_state_t            state;
  logic [OUTPORT_W-1:0]   outport;
  logic [CLASS_W-1:0]     result_next;
  logic [15:0]            setup_cnt;
  logic                   done_req;
  logic [EV_W-1:0]        irq_status;
  logic [EV_W-1:0]        irq_enable;
  logic                   start_act;
  logic                   ilock_act;
  logic                   start_ok;
  logic                   start_refused;
  logic                   done_evt;
  logic                   dph_valid;
  logic                   dph_write;
  logic [7:0]             dph_addr;
  logic                   ahb_take;
  logic                   wr_ctrl;
  logic                   wr_clr;
  logic [EV_W-1:0]        clr_bits;

  // One combined start line; no way to tell start from trigger
  assign pins.start_n = START_COMB_N_I;
  assign pins.ilock_n = INTERLOCK_N_I;

  // Input port reads zero as active
  assign start_act = ~pins.start_n;
  assign ilock_act = ~pins.ilock_n;

  // Starts only when idle and interlock in place
  assign start_ok      = start_act & ilock_act & (state == ST_IDLE);
  assign start_refused = start_act & ~start_ok;
  assign done_evt      = (state == ST_SETUP) && (setup_cnt == 16'h0001);

  // AHB-Lite address phase capture, zero wait states
  assign ahb_take = HSEL_I & HREADY_I & HTRANS_I[1];
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
    end else if (HREADY_I) begin
      dph_valid <= ahb_take;
      dph_write <= HWRITE_I;
      dph_addr  <= {HADDR_I[7:2], 2'b00};
    end
  end

  assign wr_ctrl  = dph_valid & dph_write & (dph_addr == CTRL_OFS);
  assign wr_clr   = dph_valid & dph_write & (dph_addr == IRQ_CLR_OFS);
  assign clr_bits = wr_clr ? HWDATA_I[EV_W-1:0] : '0;

  // Software registers: next result pattern, done request, enables
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      result_next <= '0;
      irq_enable  <= '0;
      done_req    <= 1'b0;
    end else begin
      if (dph_valid && dph_write && dph_addr == RESULT_OFS)
        result_next <= HWDATA_I[CLASS_W-1:0];
      if (dph_valid && dph_write && dph_addr == IRQ_EN_OFS)
        irq_enable <= HWDATA_I[EV_W-1:0];
      // Done is honoured only during a measurement
      if (state != ST_MEAS)
        done_req <= 1'b0;
      else if (wr_ctrl && HWDATA_I[0])
        done_req <= 1'b1;
    end
  end

  // Test sequencer
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state     <= ST_IDLE;
      setup_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_ok)
            state <= ST_MEAS;
        end
        ST_MEAS: begin
          // Start line released by handler is not needed to finish
          if (done_req) begin
            state     <= ST_SETUP;
            setup_cnt <= 16'(SETUP_CYCLES);
          end
        end
        ST_SETUP: begin
          if (setup_cnt == 16'h0001)
            state <= ST_IDLE;
          else
            setup_cnt <= setup_cnt - 16'h0001;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Output port: one asserts the pin; classes change only on the done request
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      outport <= OUTPORT_RST;
    end else begin
      if (start_ok) begin
        outport[BUSY_BIT] <= 1'b1;
        outport[EOT_BIT]  <= 1'b0;
      end
      // Classes load first, then setup time runs out
      if (state == ST_MEAS && done_req)
        outport[CLASS_W-1:0] <= result_next;
      if (done_evt) begin
        outport[BUSY_BIT] <= 1'b0;
        outport[EOT_BIT]  <= 1'b1;
      end
    end
  end

  // Pins are the inverted port bits, registered
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      SORT_CLASS_N_O     <= '1;
      MEASURE_ACTIVE_N_O <= 1'b1;
      END_OF_TEST_N_O    <= 1'b1;
    end else begin
      SORT_CLASS_N_O     <= ~outport[CLASS_W-1:0];
      MEASURE_ACTIVE_N_O <= ~outport[BUSY_BIT];
      END_OF_TEST_N_O    <= ~outport[EOT_BIT];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr_bits)
                  | {start_refused, done_evt, start_ok};
    end
  end

  // Interrupt level and start pulse
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_O        <= 1'b0;
      TEST_START_O <= 1'b0;
    end else begin
      IRQ_O        <= |(irq_status & irq_enable);
      TEST_START_O <= start_ok;
    end
  end

  // Read data, registered for the data phase
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (ahb_take && !HWRITE_I) begin
      case ({HADDR_I[7:2], 2'b00})
        RESULT_OFS:  HRDATA_O <= {16'h0000, result_next};
        OUTPORT_OFS: HRDATA_O <= {14'h0000, outport};
        INPORT_OFS:  HRDATA_O <= {30'h0000_0000, pins.ilock_n,
                                  pins.start_n};
        STATUS_OFS:  HRDATA_O <= {29'h0000_0000, done_req, state};
        IRQ_ST_OFS:  HRDATA_O <= {29'h0000_0000, irq_status};
        IRQ_EN_OFS:  HRDATA_O <= {29'h0000_0000, irq_enable};
        default:     HRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

endmodule : component_handler_sort_port

/* verilog/handler_port_pkg.sv */
// Constants, register map and carrier types for the handler sorting port.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus.
package handler_port_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00; // Bit0 done request
  localparam logic [7:0] RESULT_OFS  = 8'h04; // Next sorting pattern
  localparam logic [7:0] OUTPORT_OFS = 8'h08; // Output port readback
  localparam logic [7:0] INPORT_OFS  = 8'h0c; // Raw input port
  localparam logic [7:0] STATUS_OFS  = 8'h10; // Test state
  localparam logic [7:0] IRQ_ST_OFS  = 8'h14; // Sticky events
  localparam logic [7:0] IRQ_EN_OFS  = 8'h18; // Event enables
  localparam logic [7:0] IRQ_CLR_OFS = 8'h1c; // Write one to clear

  // Output port bit positions (logic one asserts the pin low)
  localparam int CLASS_W      = 16;
  localparam int BUSY_BIT     = 16;
  localparam int EOT_BIT      = 17;
  localparam int OUTPORT_W    = 18;
  // Input port bit positions
  localparam int IN_START_BIT = 0;
  localparam int IN_ILOCK_BIT = 1;

  // Interrupt event bits
  localparam int EV_START     = 0;
  localparam int EV_DONE      = 1;
  localparam int EV_REFUSED   = 2;
  localparam int EV_W         = 3;

  // Reset values
  localparam logic [OUTPORT_W-1:0] OUTPORT_RST = '0;

  // Setup time of results before the end-of-test edges
  localparam int SYS_CLK_MHZ  = 100;
  localparam int SETUP_NS     = 10000;
  localparam int SETUP_CYC    = (SETUP_NS * SYS_CLK_MHZ + 999) / 1000;

  // Test sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MEAS  = 2'b01,
    ST_SETUP = 2'b10
  } test_state_t;

  // Handler pin inputs as sampled
  typedef struct packed {
    logic ilock_n;
    logic start_n;
  } handler_in_t;

endpackage : handler_port_pkg
